// ### design/sfs_status_protect.sv
// Status word, write latch and write protection behind the serial pins
`timescale 1ns/10ps
`default_nettype none
`include "sfs_map.svh"

module sfs_status_protect
    import sfs_pkg::*;
#(
    parameter int unsigned STATUS_WRITE_TIME_US = `SFS_STATUS_WRITE_US
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Serial pins; lane 2 doubles as write_protect_n_io2
    input  wire logic        sclk_pin,
    input  wire logic        cs_n_pin,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    // Interface mode from the rest of the device
    input  wire logic        quad_command_mode,
    // Other commands handed on to the array logic
    output logic      [7:0]  cmd_code,
    output logic             cmd_strobe,
    // Program and erase requests from the array logic
    input  wire logic        op_req,
    input  wire logic        op_chip,
    input  wire logic [23:0] op_addr,
    output logic             op_go,
    input  wire logic        op_done,
    // Protect table loading
    input  wire logic        tbl_we,
    input  wire logic [3:0]  tbl_idx,
    input  wire logic [23:0] tbl_lo,
    input  wire logic [23:0] tbl_hi,
    // Live status word
    output logic      [7:0]  status_word
);

    // ------------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------------
    // Write cycle length in clocks, never below one
    localparam logic [7:0]  STATUS_RST = `SFS_STATUS_RST;
    localparam int unsigned TW_CYC_RAW = STATUS_WRITE_TIME_US * `SFS_CLK_MHZ;
    localparam int unsigned TW_CYC     = (TW_CYC_RAW < 1) ? 1 : TW_CYC_RAW;
    localparam logic [23:0] TW_CNT     = TW_CYC[23:0];

    // Number of lanes sampled per clock
    function automatic logic [2:0] lanes(input logic quad);
        lanes = quad ? 3'h4 : 3'h1;
    endfunction

    // Frame ended on a byte edge with the given byte count
    function automatic logic on_boundary(input logic [2:0] bib,
                                         input logic [1:0] nb,
                                         input logic [1:0] want);
        on_boundary = (bib == 3'h0) && (nb == want);
    endfunction

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic       s_sclk;
    logic       s_cs_n;
    logic [3:0] s_io;

    // Clock, select and lanes share one synchroniser so they stay aligned
    sfs_sync2 #(
        .W    (6),
        .INIT (6'h02)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({io_in, cs_n_pin, sclk_pin}),
        .q   ({s_io, s_cs_n, s_sclk})
    );

    // ------------------------------------------------------------------
    // Protect table
    // ------------------------------------------------------------------
    sfs_state_s  state_ff;
    sfs_state_s  nxt_state;
    logic [23:0] prot_lo;
    logic [23:0] prot_hi;

    // Table read is registered: a new level is checked one cycle later
    // level picks range
    sfs_prot_table u_table (
        .clk   (clk),
        .we    (tbl_we),
        .waddr (tbl_idx),
        .wlo   (tbl_lo),
        .whi   (tbl_hi),
        .raddr (state_ff.level),
        .rlo   (prot_lo),
        .rhi   (prot_hi)
    );

    // ------------------------------------------------------------------
    // Derived conditions
    // ------------------------------------------------------------------
    logic       sclk_rise;
    logic       sclk_fall;
    logic       frame_start;
    logic       frame_end;
    logic       in_frame;
    logic [7:0] status_now;
    logic [7:0] byte_in;
    logic [2:0] bib_next;
    logic       byte_done;
    logic       hw_protect;
    logic       addr_prot;
    logic       quad_blocked;

    // Pin edges seen after the synchronisers; the serial clock must stay
    // high or low for at least one cycle or an edge is lost
    assign sclk_rise   = s_sclk & ~state_ff.sclk_d;
    assign sclk_fall   = ~s_sclk & state_ff.sclk_d;
    assign frame_start = ~s_cs_n & state_ff.cs_n_d;
    assign frame_end   = s_cs_n & ~state_ff.cs_n_d;
    assign in_frame    = ~s_cs_n & ~state_ff.cs_n_d;

    assign byte_in  = state_ff.quad_f ? {state_ff.shift_in[3:0], s_io}
                                      : {state_ff.shift_in[6:0], s_io[0]};
    assign bib_next = state_ff.bit_in_byte + lanes(state_ff.quad_f);
    assign byte_done = (bib_next == 3'h0);

    assign status_now = {state_ff.wr_disable, state_ff.quad_en, state_ff.level,
                         state_ff.latch, state_ff.busy};

    // Protect pin counts only in single-lane use with quad enable low
    // pin is data in quad use
    assign hw_protect = state_ff.wr_disable & ~s_io[2] & ~quad_command_mode & ~state_ff.quad_en;

    // Level zero shields nothing, whatever the table holds for it
    // target inside protected range
    assign addr_prot = (state_ff.level != 4'h0) && (op_addr >= prot_lo) && (op_addr <= prot_hi);

    assign quad_blocked = ~state_ff.quad_f & ~state_ff.quad_en &
                          ((byte_in == `SFS_CMD_QUAD_READ) || (byte_in == `SFS_CMD_QUAD_READ_W) ||
                           (byte_in == `SFS_CMD_QUAD_PROG));

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    // One copy of the state is filled here and registered below
    always_comb begin
        logic [7:0] out_src;
        out_src = 8'h00;
        nxt_state = state_ff;
        nxt_state.sclk_d     = s_sclk;
        nxt_state.cs_n_d     = s_cs_n;
        nxt_state.cmd_strobe = 1'b0;
        nxt_state.op_go      = 1'b0;
        nxt_state.status_q   = status_now;

        // Frame opens: command phase
        if (frame_start) begin
            nxt_state.phase       = SFS_CMD;
            nxt_state.quad_f      = quad_command_mode;
            nxt_state.bit_in_byte = 3'h0;
            nxt_state.bytes       = 2'h0;
            nxt_state.out_bits    = 3'h0;
        end

        // Sample lanes on each rising clock
        if (in_frame && sclk_rise && (state_ff.phase != SFS_IDLE)) begin
            nxt_state.shift_in    = byte_in;
            nxt_state.bit_in_byte = bib_next;
            if (byte_done) begin
                if (state_ff.bytes != 2'h3) begin
                    nxt_state.bytes = state_ff.bytes + 2'h1;
                end
                unique case (state_ff.phase)
                    SFS_CMD: begin
                        nxt_state.cmd = byte_in;
                        if (byte_in == `SFS_CMD_READ_STATUS) begin
                            nxt_state.phase = SFS_DATA_OUT;
                        end else if (byte_in == `SFS_CMD_WRITE_STATUS) begin
                            nxt_state.phase = SFS_DATA_IN;
                        end else if (quad_blocked) begin
                            nxt_state.phase = SFS_SKIP;
                        end else begin
                            nxt_state.phase = SFS_SKIP;
                            if ((byte_in != `SFS_CMD_SET_LATCH) && (byte_in != `SFS_CMD_CLEAR_LATCH)) begin
                                nxt_state.cmd_code   = byte_in;
                                nxt_state.cmd_strobe = 1'b1;
                            end
                        end
                    end
                    SFS_DATA_IN: begin
                        if (state_ff.bytes == 2'h1) begin
                            nxt_state.wr_data = byte_in;
                        end
                    end
                    SFS_IDLE, SFS_DATA_OUT, SFS_SKIP: begin
                    end
                endcase
            end
        end

        // status shifted out on falling clock
        if (in_frame && sclk_fall && (state_ff.phase == SFS_DATA_OUT)) begin
            out_src = (state_ff.out_bits == 3'h0) ? status_now : state_ff.out_sr;
            if (state_ff.quad_f) begin
                nxt_state.io_out = out_src[7:4];
                nxt_state.io_oe  = 4'hf;
                nxt_state.out_sr = {out_src[3:0], 4'h0};
            end else begin
                nxt_state.io_out = {2'b00, out_src[7], 1'b0};
                nxt_state.io_oe  = 4'h2;
                nxt_state.out_sr = {out_src[6:0], 1'b0};
            end
            nxt_state.out_bits = state_ff.out_bits + lanes(state_ff.quad_f);
        end

        // Frame closes: act on latch and status write commands
        if (frame_end) begin
            nxt_state.phase  = SFS_IDLE;
            nxt_state.io_oe  = 4'h0;
            nxt_state.io_out = 4'h0;
            // Latch and status write commands are ignored while a cycle runs
            if (!state_ff.busy) begin
                if ((state_ff.cmd == `SFS_CMD_SET_LATCH) && (state_ff.phase == SFS_SKIP) &&
                    on_boundary(state_ff.bit_in_byte, state_ff.bytes, 2'h1)) begin
                    nxt_state.latch = 1'b1;
                end
                if ((state_ff.cmd == `SFS_CMD_CLEAR_LATCH) && (state_ff.phase == SFS_SKIP) &&
                    on_boundary(state_ff.bit_in_byte, state_ff.bytes, 2'h1)) begin
                    nxt_state.latch = 1'b0;
                end
                if ((state_ff.phase == SFS_DATA_IN) && (state_ff.bit_in_byte == 3'h0) &&
                    (state_ff.bytes >= 2'h2) && state_ff.latch && !hw_protect) begin
                    nxt_state.busy    = 1'b1;
                    nxt_state.wr_busy = 1'b1;
                    nxt_state.tw_cnt  = TW_CNT;
                end
            end
        end

        // Timed status write cycle; new bits show only when it ends
        if (state_ff.wr_busy) begin
            if (state_ff.tw_cnt <= 24'h000001) begin
                nxt_state.wr_disable = state_ff.wr_data[`SFS_BIT_WR_DISABLE];
                nxt_state.quad_en    = state_ff.wr_data[`SFS_BIT_QUAD_EN];
                nxt_state.level      = state_ff.wr_data[`SFS_BIT_LEVEL_MSB:`SFS_BIT_LEVEL_LSB];
                nxt_state.busy       = 1'b0;
                nxt_state.latch      = 1'b0;
                nxt_state.wr_busy    = 1'b0;
                nxt_state.tw_cnt     = 24'h000000;
            end else begin
                nxt_state.tw_cnt = state_ff.tw_cnt - 24'h000001;
            end
        end

        // Program and erase requests
        // A refused request leaves the latch as it was
        if (op_req && !state_ff.busy) begin
            if (state_ff.latch && (op_chip ? (state_ff.level == 4'h0) : !addr_prot)) begin
                nxt_state.op_go   = 1'b1;
                nxt_state.busy    = 1'b1;
                nxt_state.op_busy = 1'b1;
            end
        end

        if (state_ff.op_busy && op_done) begin
            nxt_state.busy    = 1'b0;
            nxt_state.latch   = 1'b0;
            nxt_state.op_busy = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state_ff            <= '0;
            state_ff.phase      <= SFS_IDLE;
            state_ff.sclk_d     <= 1'b0;
            state_ff.cs_n_d     <= 1'b1;
            state_ff.level      <= STATUS_RST[`SFS_BIT_LEVEL_MSB:`SFS_BIT_LEVEL_LSB];
            state_ff.quad_en    <= STATUS_RST[`SFS_BIT_QUAD_EN];
            state_ff.wr_disable <= STATUS_RST[`SFS_BIT_WR_DISABLE];
            state_ff.status_q   <= `SFS_STATUS_RST;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // All outputs come straight from the state register
    assign io_out      = state_ff.io_out;
    assign io_oe       = state_ff.io_oe;
    assign cmd_code    = state_ff.cmd_code;
    assign cmd_strobe  = state_ff.cmd_strobe;
    assign op_go       = state_ff.op_go;
    assign status_word = state_ff.status_q;

endmodule

`default_nettype wire

// ### design/sfs_map.svh
// Command codes, status bit positions, reset values and timing constants
`ifndef SFS_MAP_SVH
`define SFS_MAP_SVH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define SFS_CMD_WRITE_STATUS  8'h01
`define SFS_CMD_CLEAR_LATCH   8'h04
`define SFS_CMD_READ_STATUS   8'h05
`define SFS_CMD_SET_LATCH     8'h06
`define SFS_CMD_QUAD_READ     8'heb
`define SFS_CMD_QUAD_READ_W   8'he7
`define SFS_CMD_QUAD_PROG     8'h38

// ----------------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------------
`define SFS_BIT_BUSY          0
`define SFS_BIT_LATCH         1
`define SFS_BIT_LEVEL_LSB     2
`define SFS_BIT_LEVEL_MSB     5
`define SFS_BIT_QUAD_EN       6
`define SFS_BIT_WR_DISABLE    7
`define SFS_STATUS_RST        8'h00

// ----------------------------------------------------------------------
// Link and timing
// ----------------------------------------------------------------------
`define SFS_SPI_CMD_CLOCKS     8
`define SFS_QUAD_CMD_CLOCKS    2
`define SFS_CLK_MHZ            200
`define SFS_STATUS_WRITE_US    40
`define SFS_TW_CNT_W           24

`endif

// ### design/sfs_pkg.sv
// Types shared by the status and protection logic
`default_nettype none
package sfs_pkg;

    // Frame phase, one-hot
    typedef enum logic [4:0] {
        SFS_IDLE     = 5'b00001,
        SFS_CMD      = 5'b00010,
        SFS_DATA_IN  = 5'b00100,
        SFS_DATA_OUT = 5'b01000,
        SFS_SKIP     = 5'b10000
    } sfs_phase_e;

    // Whole state of the status block
    typedef struct packed {
        sfs_phase_e  phase;
        logic        sclk_d;
        logic        cs_n_d;
        logic        quad_f;
        logic [2:0]  bit_in_byte;
        logic [1:0]  bytes;
        logic [7:0]  shift_in;
        logic [7:0]  cmd;
        logic [7:0]  wr_data;
        logic [7:0]  out_sr;
        logic [2:0]  out_bits;
        logic        busy;
        logic        latch;
        logic [3:0]  level;
        logic        quad_en;
        logic        wr_disable;
        logic        wr_busy;
        logic        op_busy;
        logic [23:0] tw_cnt;
        logic [3:0]  io_out;
        logic [3:0]  io_oe;
        logic [7:0]  cmd_code;
        logic        cmd_strobe;
        logic        op_go;
        logic [7:0]  status_q;
    } sfs_state_s;

endpackage
`default_nettype wire

// ### design/sfs_sync2.sv
// Two-flop synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module sfs_sync2 #(
    parameter int unsigned      W    = 1,
    parameter logic [W-1:0]     INIT = '0
) (
    // Clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // Asynchronous in, synchronous out
    input  wire logic [W-1:0]   d,
    output logic      [W-1:0]   q
);

    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk) begin
        if (rst) begin
            meta_ff <= INIT;
            q_ff    <= INIT;
        end else begin
            meta_ff <= d;
            q_ff    <= meta_ff;
        end
    end

    assign q = q_ff;

endmodule

`default_nettype wire

// ### design/sfs_prot_table.sv
// Protect level to address range table with registered read
`timescale 1ns/10ps
`default_nettype none

module sfs_prot_table (
    // Clock
    input  wire logic        clk,
    // Write port
    input  wire logic        we,
    input  wire logic [3:0]  waddr,
    input  wire logic [23:0] wlo,
    input  wire logic [23:0] whi,
    // Read port
    input  wire logic [3:0]  raddr,
    output logic      [23:0] rlo,
    output logic      [23:0] rhi
);

    logic [47:0] mem [16];
    logic [47:0] rd_ff;

    // One write and one registered read per cycle
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= {whi, wlo};
        end
        rd_ff <= mem[raddr];
    end

    assign rlo = rd_ff[23:0];
    assign rhi = rd_ff[47:24];

endmodule

`default_nettype wire

// ### bench/sfs_status_protect_checker.sv
// Assertion checker for the status and protection block
`timescale 1ns/10ps
`default_nettype none
`include "sfs_map.svh"

module sfs_status_protect_checker (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Pins and mode
    input  wire logic       cs_n_pin,
    input  wire logic [3:0] io_in,
    input  wire logic [3:0] io_oe,
    input  wire logic       quad_command_mode,
    // Commands, operations and status
    input  wire logic [7:0] cmd_code,
    input  wire logic       cmd_strobe,
    input  wire logic       op_chip,
    input  wire logic       op_go,
    input  wire logic       op_done,
    input  wire logic [7:0] status_word
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Operation steps
    // ------------------------------------------------------------------
    sequence s_busy_next;
        ##1 status_word[0];
    endsequence
    sequence s_idle_after;
        ##2 (status_word[1:0] == 2'b00);
    endsequence

    chk_go_busy: assert property (op_go |-> s_busy_next)
        else $error("busy missing after op_go");
    chk_go_latch: assert property (op_go |-> status_word[1] && !status_word[0])
        else $error("op_go without latch");
    chk_chip_level: assert property (op_go && $past(op_chip) |-> status_word[5:2] == 4'h0)
        else $error("chip erase with level set");
    chk_done_idle: assert property (op_done && status_word[0] |-> s_idle_after)
        else $error("busy or latch kept after done");
    chk_busy_latch: assert property ($fell(status_word[0]) |-> !status_word[1])
        else $error("latch kept after busy fell");
    chk_hw_lock: assert property ($rose(status_word[0]) && !$past(op_go) |->
        !($past(status_word[7], 6) && !$past(io_in[2], 6) && !$past(status_word[6], 6)
          && !$past(quad_command_mode, 6)))
        else $error("status write in locked mode");
    chk_oe_idle: assert property (cs_n_pin [*8] ##1 cs_n_pin |-> io_oe == 4'h0)
        else $error("lane driven outside frame");
    chk_spi_lanes: assert property (!quad_command_mode |-> (io_oe & 4'hd) == 4'h0)
        else $error("extra lane driven");
    chk_quad_drop: assert property (cmd_strobe && !quad_command_mode && !status_word[6] |->
        !(cmd_code inside {`SFS_CMD_QUAD_READ, `SFS_CMD_QUAD_READ_W, `SFS_CMD_QUAD_PROG}))
        else $error("quad code passed with quad disabled");
endmodule

bind sfs_status_protect sfs_status_protect_checker i_chk (
    .clk(clk), .rst(rst), .cs_n_pin(cs_n_pin), .io_in(io_in), .io_oe(io_oe),
    .quad_command_mode(quad_command_mode), .cmd_code(cmd_code), .cmd_strobe(cmd_strobe),
    .op_chip(op_chip), .op_go(op_go), .op_done(op_done), .status_word(status_word)
);
`default_nettype wire

// ### bench/sfs_host_model.sv
// Host serial controller model driving the frame pins
`timescale 1ns/10ps
`default_nettype none

module sfs_host_model #(
    parameter int HALF = 16
) (
    // Clock
    input  wire logic       clk,
    // Protect level and device lanes
    input  wire logic       wp_n,
    input  wire logic [3:0] io_out,
    // Frame pins
    output logic            sclk_pin,
    output logic            cs_n_pin,
    output logic      [3:0] io_in
);
    logic [3:0] drv;
    logic       qf;

    // lane two is the protect pin outside quad frames
    assign io_in = qf ? drv : {drv[3], wp_n, drv[1:0]};

    initial begin
        sclk_pin = 1'b0;
        cs_n_pin = 1'b1;
        drv      = 4'h5;
        qf       = 1'b0;
    end

    // one frame, msb first, clock idles low
    task automatic xfer(input logic q, input logic [15:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        @(posedge clk) #1;
        qf       = q;
        cs_n_pin = 1'b0;
        for (int i = 0; i < n; i++) begin
            drv = q ? tx[15:12] : {~drv[3], 1'b0, ~drv[1], tx[15]};
            tx  = q ? tx << 4 : tx << 1;
            repeat (HALF) @(posedge clk);
            #1;
            rx       = q ? {rx[3:0], io_out} : {rx[6:0], io_out[1]};
            sclk_pin = 1'b1;
            repeat (HALF) @(posedge clk);
            #1;
            sclk_pin = 1'b0;
        end
        repeat (HALF) @(posedge clk);
        #1;
        cs_n_pin = 1'b1;
        drv      = ~drv;  // Released lanes show the inverse
        qf       = 1'b0;
        repeat (2 * HALF) @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

// ### bench/sfs_status_protect_tb.sv
// Self-checking bench for the status and protection block
`timescale 1ns/10ps
`default_nettype none

module sfs_status_protect_tb;
    localparam int US = 4;
    localparam int TW = US * 200;  // Write cycle in clocks

    logic        clk, rst, wp_n, qmode, sclk, cs_n, strobe, go, b_d;
    logic        op_req, op_chip, op_done, tbl_we;
    logic [3:0]  io_in, io_out, io_oe, tbl_idx;
    logic [7:0]  code, sw, rx;
    logic [23:0] op_addr, tbl_lo, tbl_hi, a;
    int          err_total, total_checks, lvl, qe, status_write_disable, write_latch, seen, cyc, l, c, t_rise;

    sfs_status_protect #(.STATUS_WRITE_TIME_US(US)) i_dut (
        .clk(clk), .rst(rst), .sclk_pin(sclk), .cs_n_pin(cs_n), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .quad_command_mode(qmode), .cmd_code(code),
        .cmd_strobe(strobe), .op_req(op_req), .op_chip(op_chip), .op_addr(op_addr),
        .op_go(go), .op_done(op_done), .tbl_we(tbl_we), .tbl_idx(tbl_idx),
        .tbl_lo(tbl_lo), .tbl_hi(tbl_hi), .status_word(sw)
    );
    sfs_host_model i_host (
        .clk(clk), .wp_n(wp_n), .io_out(io_out), .sclk_pin(sclk), .cs_n_pin(cs_n), .io_in(io_in)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Cycle count, busy rise and command strobe watch
    always @(posedge clk) begin
        cyc <= cyc + 1;
        b_d <= sw[0];
        if (sw[0] === 1'b1 && b_d !== 1'b1) t_rise <= cyc;
        if (strobe === 1'b1) seen <= 1;
    end

    // ------------------------------------------------------------------
    // Model and checks
    // ------------------------------------------------------------------
    function automatic logic [7:0] exp_sw(input int b);
        return {status_write_disable[0], qe[0], lvl[3:0], write_latch[0], b[0]};
    endfunction

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic rd(input int b);
        i_host.xfer(1'b0, 16'h0500, 16, rx);
        chk8("read_status", exp_sw(b), rx);
        chk8("status_word", exp_sw(b), sw);
    endtask

    task automatic cmd(input logic [7:0] k);
        i_host.xfer(1'b0, {k, 8'h00}, 8, rx);
    endtask

    task automatic wrs(input logic [7:0] d, input int n);
        int ok, k, t0;
        ok = write_latch && n == 16 && !(status_write_disable && !wp_n && !qe);
        i_host.xfer(1'b0, {8'h01, d}, n, rx);
        k = 0;
        while (sw[0] !== 1'b1 && k < 20) begin
            @(posedge clk) #1;
            k++;
        end
        if (ok) begin
            t0 = t_rise;
            rd(1);
            while (sw[0] === 1'b1 && cyc - t0 < 2 * TW) @(posedge clk) #1;
            chk8("busy_len", 8'h01, 8'(cyc - t0 >= TW - 1 && cyc - t0 <= TW + 2));
            status_write_disable = d[7];
            qe   = d[6];
            lvl  = d[5:2];
            write_latch  = 0;
        end
        rd(0);
    endtask

    task automatic op(input logic ch, input logic [23:0] ad);
        int e, g;
        e = write_latch && (ch ? lvl == 0 : (lvl == 0 || ad < lvl * 65536 || ad > lvl * 65536 + 65535));
        g = 0;
        @(posedge clk) #1;
        op_req  = 1'b1;
        op_chip = ch;
        op_addr = ad;
        @(posedge clk) #1;
        op_req = 1'b0;
        repeat (3) begin
            if (go === 1'b1) g = 1;
            @(posedge clk) #1;
        end
        chk8("op_go", 8'(e), 8'(g));
        if (e) begin
            repeat (10) @(posedge clk);
            #1 op_done = 1'b1;
            @(posedge clk) #1;
            op_done = 1'b0;
            write_latch     = 0;
            repeat (4) @(posedge clk);
        end
        rd(0);
    endtask

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        {rst, wp_n, qmode, op_req, op_chip, op_done, tbl_we} = 7'b1100000;
        {op_addr, tbl_lo, tbl_hi, tbl_idx} = '0;
        {err_total, total_checks, lvl, qe, status_write_disable, write_latch, seen, cyc, t_rise} = '0;
        void'($urandom(86088));
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        // Level n (1 to 15) protects 64K block n
        for (int i = 0; i < 16; i++) begin
            @(posedge clk) #1;
            {tbl_we, tbl_idx, tbl_lo, tbl_hi} = {1'b1, 4'(i), 24'(i << 16), 24'((i << 16) | 24'hffff)};
        end
        @(posedge clk) #1 tbl_we = 1'b0;
        chk8("reset_status", 8'h00, sw);
        rd(0);
        wrs(8'h3c, 16);
        op(1'b0, 24'h020000);
        cmd(8'h06);
        write_latch = 1;
        rd(0);
        wrs(8'h3c, 12);
        cmd(8'h04);
        write_latch = 0;
        rd(0);
        for (int i = 0; i < 3; i++) begin
            wp_n = (i != 1);
            cmd(8'h06);
            write_latch = 1;
            wrs(i == 0 ? 8'h8c : 8'h00, 16);
        end
        for (int i = 0; i < 10; i++) begin
            l = i < 4 ? (i == 3 ? 0 : 1) : $urandom_range(0, 3);
            c = i < 4 ? (i == 0 || i == 3) : ($urandom_range(0, 3) == 0);
            a = i < 4 ? (i == 2 ? 24'h018000 : 24'h000100) : 24'($urandom_range(0, 24'h5ffff));
            cmd(8'h06);
            write_latch = 1;
            wrs({2'b00, 4'(l), 2'b00}, 16);
            cmd(8'h06);
            write_latch = 1;
            op(c[0], a);
        end
        seen = 0;
        cmd(8'heb);
        chk8("quad_blocked", 8'h00, 8'(seen));
        seen = 0;
        cmd(8'h9f);
        chk8("plain_code", 8'h9f, seen ? code : 8'h00);
        cmd(8'h06);
        write_latch = 1;
        wrs(8'h40, 16);
        seen = 0;
        cmd(8'heb);
        chk8("quad_open", 8'h01, 8'(seen));
        qmode = 1'b1;
        i_host.xfer(1'b1, 16'h0500, 4, rx);
        chk8("quad_read", exp_sw(0), rx);
        qmode = 1'b0;
        @(posedge clk) #1 rst = 1'b1;
        repeat (5) @(posedge clk);
        #1 rst = 1'b0;
        {lvl, qe, status_write_disable, write_latch} = '0;
        repeat (4) @(posedge clk);
        rd(0);
        print_verdict();
    end

    // Watchdog
    initial begin
        repeat (90000) @(posedge clk);
        err_total++;
        print_verdict();
    end
endmodule
`default_nettype wire
